/* rtl/irq_active_prio_regs.sv */
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// [R1] active flag reads 1 when active or active-and-pending, else 0
// [R2] active flags of unimplemented interrupts read zero
// [R3] secure interrupts' active flags read zero to non-secure reads
// [R4] active-flag register count is line group count plus one, from zero
// [R5] active register zero (ids 0-31) is banked per processor
// [R6] id N flag at 0x300 plus 4*(N/32), bit N mod 32
// [R7] each interrupt holds its own 8-bit priority field
// [R8] priority registers take single-byte and full-word accesses
// [R9] unimplemented interrupts' priority fields read zero, ignore writes
// [R10] at least priority bits [7:4] kept; missing low bits RAZ/WI
// [R11] secure interrupts' priority fields RAZ/WI to non-secure accesses
// [R12] lockdown can freeze priorities of lockable secure shared interrupts
// [R13] priority rewrites take effect at once, active interrupts included
// [R14] priority register count is 8 times line group count plus one
// [R15] priority registers 0-7 (ids 0-31) are banked per processor
// [R16] lower priority value means higher urgency
// [R17] id N priority at 0x400 plus 4*(N/4), lane N mod 4
// [R18] both arrays always present, reachable by secure and non-secure
// [R19] active-flag writes are ignored; acknowledge/complete change them
module irq_active_prio_regs
    import irq_regs_pkg::*;
#(
    parameter int                 LINE_GROUP_COUNT = 1,
    parameter int                 NUM_CPUS         = 2,
    parameter int                 PRIO_BITS        = 8,
    parameter bit                 SECURITY_EXT     = 1'b1,
    parameter bit                 LOCKDOWN_IMPL    = 1'b1,
    parameter int                 LOCKABLE_SPIS    = 8,
    parameter int                 NUM_IRQ          = PRIV_IRQS * (LINE_GROUP_COUNT + 1),
    parameter logic [NUM_IRQ-1:0] IMPL_MASK        = '1
) (
    // clock and reset
    input  wire logic                 SYS_CLK,
    input  wire logic                 RST,
    // register port
    input  wire logic [ADDR_W-1:0]    BUS_ADDR,
    input  wire logic [DATA_W-1:0]    BUS_WDATA,
    input  wire logic [LANES-1:0]     BUS_BE,
    input  wire logic                 BUS_WR,
    input  wire logic                 BUS_RD,
    input  wire logic                 BUS_NONSECURE,
    input  wire logic [CPU_ID_W-1:0]  BUS_CPU,
    output logic      [DATA_W-1:0]    BUS_RDATA,
    // security configuration and lockdown
    input  wire logic [NUM_IRQ-1:0]   IRQ_SECURE,
    input  wire logic                 CFG_LOCK,
    // acknowledge and completion flow
    input  wire logic                 ACK_VALID,
    input  wire logic [IRQ_ID_W-1:0]  ACK_ID,
    input  wire logic [CPU_ID_W-1:0]  ACK_CPU,
    input  wire logic                 DONE_VALID,
    input  wire logic [IRQ_ID_W-1:0]  DONE_ID,
    input  wire logic [CPU_ID_W-1:0]  DONE_CPU,
    // highest-urgency candidate query
    input  wire logic [NUM_IRQ-1:0]   CAND_REQ,
    input  wire logic [CPU_ID_W-1:0]  CAND_CPU,
    output logic                      BEST_VALID,
    output logic      [IRQ_ID_W-1:0]  BEST_ID,
    output logic      [PRIO_W-1:0]    BEST_PRIO
);

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int SPI_N     = (NUM_IRQ > PRIV_IRQS) ? NUM_IRQ - PRIV_IRQS : 1;
    localparam int ACT_REGS  = LINE_GROUP_COUNT + 1;
    localparam int PRIO_REGS = PRIO_REGS_GROUP * (LINE_GROUP_COUNT + 1);
    localparam int ACT_WORD0 = int'(ACTIVE_FLAGS_BASE[ADDR_W-1:2]);
    localparam int PRIO_WORD0 = int'(PRIO_BYTES_BASE[ADDR_W-1:2]);
    localparam logic [PRIO_W-1:0] PRIO_MASK =
        PRIO_W'(((1 << PRIO_BITS) - 1) << (PRIO_W - PRIO_BITS));

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NUM_CPUS-1:0][PRIV_IRQS-1:0]             act_priv;
        logic [SPI_N-1:0]                               act_spi;
        logic [NUM_CPUS-1:0][PRIV_IRQS-1:0][PRIO_W-1:0] prio_priv;
        logic [SPI_N-1:0][PRIO_W-1:0]                   prio_spi;
        logic [DATA_W-1:0]                              rdata;
        logic                                           best_valid;
        logic [IRQ_ID_W-1:0]                            best_id;
        logic [PRIO_W-1:0]                              best_prio;
    } state_t;

    state_t   state_reg;
    state_t   state_next;
    bus_req_t bus;

    logic [NUM_IRQ-1:0][PRIO_W-1:0] view_prio;
    logic                           sel_found;
    logic [IRQ_ID_W-1:0]            sel_id;
    logic [PRIO_W-1:0]              sel_prio;

    assign bus = '{addr: BUS_ADDR, wdata: BUS_WDATA, be: BUS_BE, wr: BUS_WR,
                   rd: BUS_RD, nonsecure: BUS_NONSECURE, cpu: BUS_CPU};

    // ------------------------------------------------------------
    // access filters
    // ------------------------------------------------------------
    function automatic logic visible(input int id, input logic nonsec, input logic sec);
        visible = IMPL_MASK[id]                                   // [R2] [R9]
                  && !(SECURITY_EXT && nonsec && sec);              // [R3] [R11] [R18]
    endfunction

    function automatic logic locked(input int id, input logic sec, input logic lock);
        locked = LOCKDOWN_IMPL && lock && sec && id >= PRIV_IRQS
                 && id < PRIV_IRQS + LOCKABLE_SPIS;                  // [R12]
    endfunction

    // ------------------------------------------------------------
    // priority view of the candidate processor
    // ------------------------------------------------------------
    generate
        for (genvar g = 0; g < NUM_IRQ; g++) begin : g_view
            if (g < PRIV_IRQS) begin : g_priv
                assign view_prio[g] = (int'(CAND_CPU) < NUM_CPUS)
                    ? state_reg.prio_priv[int'(CAND_CPU) % NUM_CPUS][g] : PRIO_RESET;
            end else begin : g_spi
                assign view_prio[g] = state_reg.prio_spi[g - PRIV_IRQS];
            end
        end
    endgenerate

    prio_min_select #(
        .NUM_IRQ (NUM_IRQ)
    ) u_select (
        .prio     (view_prio),
        .req      (CAND_REQ & IMPL_MASK),
        .found    (sel_found),
        .win_id   (sel_id),
        .win_prio (sel_prio)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        int  word;
        int  cpu;
        int  m;
        int  id;
        logic cpu_ok;
        logic act_hit;
        logic prio_hit;
        logic [PRIO_W-1:0] field;
        word     = int'(bus.addr[ADDR_W-1:2]);
        cpu      = int'(bus.cpu);
        cpu_ok   = cpu < NUM_CPUS;
        m        = 0;
        id       = 0;
        field    = PRIO_RESET;
        act_hit  = word >= ACT_WORD0 && word < ACT_WORD0 + ACT_REGS;     // [R4]
        prio_hit = word >= PRIO_WORD0 && word < PRIO_WORD0 + PRIO_REGS;  // [R14]
        state_next       = state_reg;
        state_next.rdata = RDATA_RESET;

        // acknowledge sets, completion clears; set wins on a clash
        if (DONE_VALID && int'(DONE_ID) < NUM_IRQ) begin                // [R19]
            if (int'(DONE_ID) < PRIV_IRQS) begin
                if (int'(DONE_CPU) < NUM_CPUS)
                    state_next.act_priv[int'(DONE_CPU) % NUM_CPUS][int'(DONE_ID) % PRIV_IRQS] = 1'b0;
            end else begin
                state_next.act_spi[(int'(DONE_ID) - PRIV_IRQS) % SPI_N] = 1'b0;
            end
        end
        if (ACK_VALID && int'(ACK_ID) < NUM_IRQ && IMPL_MASK[int'(ACK_ID)]) begin // [R1] [R19]
            if (int'(ACK_ID) < PRIV_IRQS) begin
                if (int'(ACK_CPU) < NUM_CPUS)
                    state_next.act_priv[int'(ACK_CPU) % NUM_CPUS][int'(ACK_ID) % PRIV_IRQS] = 1'b1;
            end else begin
                state_next.act_spi[(int'(ACK_ID) - PRIV_IRQS) % SPI_N] = 1'b1;
            end
        end

        // active flag reads; writes to this array fall through unused
        if (bus.rd && act_hit) begin
            m = word - ACT_WORD0;
            for (int b = 0; b < FLAGS_PER_REG; b++) begin
                id = m * FLAGS_PER_REG + b;                               // [R6]
                if (id < NUM_IRQ && visible(id, bus.nonsecure, IRQ_SECURE[id])) begin
                    if (id < PRIV_IRQS)
                        state_next.rdata[b] = cpu_ok
                            && state_reg.act_priv[cpu % NUM_CPUS][id % PRIV_IRQS]; // [R5]
                    else
                        state_next.rdata[b] = state_reg.act_spi[(id - PRIV_IRQS) % SPI_N];
                end
            end
        end

        // priority reads and byte-lane writes
        if ((bus.rd || bus.wr) && prio_hit) begin
            m = word - PRIO_WORD0;
            for (int k = 0; k < FIELDS_PER_REG; k++) begin
                id = m * FIELDS_PER_REG + k;                              // [R17]
                if (id < NUM_IRQ && visible(id, bus.nonsecure, IRQ_SECURE[id])) begin
                    if (id < PRIV_IRQS)
                        field = cpu_ok
                            ? state_reg.prio_priv[cpu % NUM_CPUS][id % PRIV_IRQS]
                            : PRIO_RESET;                                  // [R15]
                    else
                        field = state_reg.prio_spi[(id - PRIV_IRQS) % SPI_N];
                    if (bus.rd)
                        state_next.rdata[k*PRIO_W +: PRIO_W] = field & PRIO_MASK; // [R10]
                    if (bus.wr && bus.be[k]
                        && !locked(id, IRQ_SECURE[id], CFG_LOCK)) begin   // [R8] [R12]
                        field = bus.wdata[k*PRIO_W +: PRIO_W] & PRIO_MASK;  // [R7] [R10]
                        if (id < PRIV_IRQS) begin
                            if (cpu_ok)
                                state_next.prio_priv[cpu % NUM_CPUS][id % PRIV_IRQS] = field; // [R15]
                        end else begin
                            state_next.prio_spi[(id - PRIV_IRQS) % SPI_N] = field; // [R13]
                        end
                    end
                end
            end
        end

        // registered winner of the candidate set
        state_next.best_valid = sel_found;                              // [R16]
        state_next.best_id    = sel_id;
        state_next.best_prio  = sel_prio & PRIO_MASK;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign BUS_RDATA  = state_reg.rdata;
    assign BEST_VALID = state_reg.best_valid;
    assign BEST_ID    = state_reg.best_id;
    assign BEST_PRIO  = state_reg.best_prio;

endmodule

`default_nettype wire

/* inc/irq_regs_pkg.sv */
package irq_regs_pkg;

    // ------------------------------------------------------------
    // bus and field geometry
    // ------------------------------------------------------------
    localparam int ADDR_W          = 12;
    localparam int DATA_W          = 32;
    localparam int LANES           = 4;
    localparam int CPU_ID_W        = 3;
    localparam int IRQ_ID_W        = 10;
    localparam int PRIO_W          = 8;
    localparam int MIN_PRIO_BITS   = 4;
    localparam int PRIV_IRQS       = 32;
    localparam int FLAGS_PER_REG   = 32;
    localparam int FIELDS_PER_REG  = 4;
    localparam int PRIO_REGS_GROUP = 8;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ACTIVE_FLAGS_BASE = 12'h300;
    localparam logic [ADDR_W-1:0] PRIO_BYTES_BASE   = 12'h400;
    localparam logic [DATA_W-1:0] RDATA_RESET       = 32'h0000_0000;
    localparam logic [PRIO_W-1:0] PRIO_RESET        = 8'h00;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
        logic [LANES-1:0]    be;
        logic                wr;
        logic                rd;
        logic                nonsecure;
        logic [CPU_ID_W-1:0] cpu;
    } bus_req_t;

    typedef struct packed {
        logic                valid;
        logic [IRQ_ID_W-1:0] id;
        logic [CPU_ID_W-1:0] cpu;
    } irq_event_t;

endpackage

/* rtl/prio_min_select.sv */
`timescale 1ns/1ps
`default_nettype none

module prio_min_select
    import irq_regs_pkg::*;
#(
    parameter int NUM_IRQ = 64
) (
    // candidates
    input  wire logic [NUM_IRQ-1:0][PRIO_W-1:0] prio,
    input  wire logic [NUM_IRQ-1:0]             req,
    // winner
    output logic                                found,
    output logic [IRQ_ID_W-1:0]                 win_id,
    output logic [PRIO_W-1:0]                   win_prio
);

    // ------------------------------------------------------------
    // lowest value wins, lowest id breaks ties
    // ------------------------------------------------------------
    always_comb begin
        found    = 1'b0;
        win_id   = '0;
        win_prio = '1;
        for (int i = 0; i < NUM_IRQ; i++) begin
            if (req[i] && (!found || prio[i] < win_prio)) begin  // [R16]
                found    = 1'b1;
                win_id   = IRQ_ID_W'(i);
                win_prio = prio[i];
            end
        end
    end

endmodule

`default_nettype wire

/* tb/irq_active_prio_regs_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_active_prio_regs_checker
    import irq_regs_pkg::*;
#(
    parameter int NUM_IRQ  = 64,
    parameter int NUM_CPUS = 2
) (
    // clock and reset
    input wire logic                SYS_CLK,
    input wire logic                RST,
    // register port
    input wire logic [ADDR_W-1:0]   BUS_ADDR,
    input wire logic [DATA_W-1:0]   BUS_WDATA,
    input wire logic [LANES-1:0]    BUS_BE,
    input wire logic                BUS_WR,
    input wire logic                BUS_RD,
    input wire logic                BUS_NONSECURE,
    input wire logic [CPU_ID_W-1:0] BUS_CPU,
    input wire logic [DATA_W-1:0]   BUS_RDATA,
    // configuration and events
    input wire logic [NUM_IRQ-1:0]  IRQ_SECURE,
    input wire logic                CFG_LOCK,
    input wire logic                ACK_VALID,
    input wire logic [IRQ_ID_W-1:0] ACK_ID,
    input wire logic [CPU_ID_W-1:0] ACK_CPU,
    input wire logic                DONE_VALID,
    input wire logic [IRQ_ID_W-1:0] DONE_ID,
    input wire logic [CPU_ID_W-1:0] DONE_CPU
);
    function automatic logic [31:0] lanes(input logic [3:0] b);
        return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    endfunction
    logic [9:0]  widx;
    logic [31:0] sec_act, sec_pri, be_mask;
    logic        act_hit, pri_hit, evt;
    assign widx    = BUS_ADDR[11:2];
    assign act_hit = widx >= 10'h0C0 && widx < 10'(192 + NUM_IRQ / 32);
    assign pri_hit = widx >= 10'h100 && widx < 10'(256 + NUM_IRQ / 4);
    assign evt     = ACK_VALID || DONE_VALID;
    assign sec_act = 32'(IRQ_SECURE >> (32 * (widx - 10'h0C0)));
    assign sec_pri = lanes(4'(IRQ_SECURE >> (4 * (widx - 10'h100))));
    assign be_mask = lanes(BUS_BE);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);
    sequence ack_then_rd;
        (ACK_VALID && ACK_ID < NUM_IRQ && ACK_CPU < NUM_CPUS) ##1 (BUS_RD && !BUS_NONSECURE
        && widx == 10'h0C0 + $past(ACK_ID) / 32 && (BUS_CPU == $past(ACK_CPU) || $past(ACK_ID) > 31));
    endsequence
    sequence done_then_rd;
        (DONE_VALID && !ACK_VALID && DONE_ID < NUM_IRQ && DONE_CPU < NUM_CPUS) ##1 (BUS_RD
        && !BUS_NONSECURE && widx == 10'h0C0 + $past(DONE_ID) / 32
        && (BUS_CPU == $past(DONE_CPU) || $past(DONE_ID) > 31));
    endsequence
    sequence pri_wr_rd;
        (BUS_WR && pri_hit && !BUS_NONSECURE && !CFG_LOCK && BUS_CPU < NUM_CPUS) ##1
        (BUS_RD && $stable(widx) && $stable(BUS_CPU) && !BUS_NONSECURE);
    endsequence
    sequence act_rd_wr_rd;
        (BUS_RD && act_hit && !evt) ##1 (BUS_WR && !evt && $stable(widx) && $stable(IRQ_SECURE))
        ##1 (BUS_RD && $stable(widx) && BUS_CPU == $past(BUS_CPU, 2)
        && BUS_NONSECURE == $past(BUS_NONSECURE, 2) && $stable(IRQ_SECURE));
    endsequence
    chk_ack_sets_flag: assert property (ack_then_rd |=> BUS_RDATA[$past(ACK_ID[4:0], 2)])
        else $error("active flag missing after acknowledge");
    chk_done_clears: assert property (done_then_rd |=> !BUS_RDATA[$past(DONE_ID[4:0], 2)])
        else $error("active flag still set after completion");
    chk_act_secure_raz: assert property (BUS_RD && BUS_NONSECURE && act_hit
        |=> (BUS_RDATA & $past(sec_act)) == '0) else $error("secure active flag seen");
    chk_pri_secure_raz: assert property (BUS_RD && BUS_NONSECURE && pri_hit
        |=> (BUS_RDATA & $past(sec_pri)) == '0) else $error("secure priority seen");
    chk_act_range_raz: assert property (BUS_RD && widx >= 10'(192 + NUM_IRQ / 32)
        && widx < 10'h100 |=> BUS_RDATA == '0) else $error("extra active register not zero");
    chk_pri_range_raz: assert property (BUS_RD && widx >= 10'(256 + NUM_IRQ / 4)
        && widx < 10'h200 |=> BUS_RDATA == '0) else $error("extra priority register not zero");
    chk_pri_byte_rw: assert property (pri_wr_rd |=>
        ((BUS_RDATA ^ $past(BUS_WDATA, 2)) & $past(be_mask, 2)) == '0) else $error("lane lost");
    chk_act_wr_ignored: assert property (act_rd_wr_rd |=> BUS_RDATA == $past(BUS_RDATA, 2))
        else $error("active flags changed by a write");
endmodule
bind irq_active_prio_regs irq_active_prio_regs_checker #(.NUM_IRQ(NUM_IRQ), .NUM_CPUS(NUM_CPUS)) u_chk (
    .SYS_CLK(SYS_CLK), .RST(RST), .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA), .BUS_BE(BUS_BE),
    .BUS_WR(BUS_WR), .BUS_RD(BUS_RD), .BUS_NONSECURE(BUS_NONSECURE), .BUS_CPU(BUS_CPU),
    .BUS_RDATA(BUS_RDATA), .IRQ_SECURE(IRQ_SECURE), .CFG_LOCK(CFG_LOCK), .ACK_VALID(ACK_VALID),
    .ACK_ID(ACK_ID), .ACK_CPU(ACK_CPU), .DONE_VALID(DONE_VALID), .DONE_ID(DONE_ID),
    .DONE_CPU(DONE_CPU));
`default_nettype wire

/* tb/cpu_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model
    import irq_regs_pkg::*;
(
    // bench request in, pins out
    input  wire logic     clk,
    input  wire bus_req_t req,
    output bus_req_t      pins
);
    bus_req_t last_reg = '0;
    // idle cycles show the inverse of the last request's address and write data
    always @(posedge clk) if (req.wr || req.rd) last_reg <= req;
    always_comb begin
        pins = req;
        if (!(req.wr || req.rd)) {pins.addr, pins.wdata} = ~{last_reg.addr, last_reg.wdata};
    end
endmodule
`default_nettype wire

/* tb/irq_active_prio_regs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_active_prio_regs_tb_top
    import irq_regs_pkg::*;
;
    logic        sys_clk = 1'b0, rst = 1'b1, cfg_lock = 1'b0, lk = 1'b0, nsv = 1'b0;
    logic        ack_valid = 1'b0, done_valid = 1'b0, best_valid, am [3][64];
    logic [2:0]  ev_cpu = '0, cand_cpu = '0, cpv = '0;
    logic [9:0]  ev_id = '0, best_id;
    logic [7:0]  best_prio, pm [3][64];
    logic [63:0] irq_secure = '0, cand_req = '0, sec = '0;
    logic [31:0] rdata, seed = 32'h4DCE7090, rq [$];
    bus_req_t    req = '0, pins;
    int          miscompares = 0, checked = 0;
    cpu_bus_model u_cpu (.clk(sys_clk), .req(req), .pins(pins));
    irq_active_prio_regs dut (.SYS_CLK(sys_clk), .RST(rst), .BUS_ADDR(pins.addr),
        .BUS_WDATA(pins.wdata), .BUS_BE(pins.be), .BUS_WR(pins.wr), .BUS_RD(pins.rd),
        .BUS_NONSECURE(pins.nonsecure), .BUS_CPU(pins.cpu), .BUS_RDATA(rdata),
        .IRQ_SECURE(irq_secure), .CFG_LOCK(cfg_lock), .ACK_VALID(ack_valid), .ACK_ID(ev_id),
        .ACK_CPU(ev_cpu), .DONE_VALID(done_valid), .DONE_ID(ev_id), .DONE_CPU(ev_cpu),
        .CAND_REQ(cand_req), .CAND_CPU(cand_cpu), .BEST_VALID(best_valid), .BEST_ID(best_id),
        .BEST_PRIO(best_prio));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int bk(input int id);
        return id < 32 ? int'(cpv) : 0;
    endfunction
    function automatic logic [31:0] exp_word(input int m);
        int id;
        exp_word = '0;
        for (int k = 0; k < 32; k++) begin
            id = m < 256 ? 32 * m - 6144 + k : 4 * m - 1024 + k;
            if (!((m >= 192 && m < 194) || (m >= 256 && m < 272 && k < 4))) continue;
            if ((id < 32 && cpv > 1) || (nsv && sec[id])) continue;
            if (m < 256) exp_word[k] = am[bk(id)][id];
            else exp_word[8*k+:8] = pm[bk(id)][id];
        end
    endfunction
    task automatic chk(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic put(input bus_req_t r, input logic av, input logic dv);
        req <= r;
        ack_valid <= av;
        done_valid <= dv;
        ev_cpu <= cpv;
        @(posedge sys_clk);
    endtask
    task automatic rd(input int m);
        put('{12'(4 * m), rnd(), 4'h0, 1'b0, 1'b1, nsv, cpv}, 1'b0, 1'b0);
        rq.push_back(exp_word(m));
    endtask
    task automatic wr(input int m, input logic [31:0] d, input logic [3:0] b);
        int id;
        for (int k = 0; k < 4; k++) begin
            id = 4 * m - 1024 + k;
            if (b[k] && m >= 256 && m < 272 && (id > 31 || cpv < 2) && !(nsv && sec[id])
                && !(lk && sec[id] && id > 31 && id < 40)) pm[bk(id)][id] = d[8*k+:8];
        end
        put('{12'(4 * m), d, b, 1'b1, 1'b0, nsv, cpv}, 1'b0, 1'b0);
    endtask
    task automatic ev(input logic set, input logic clr, input int id);
        ev_id <= 10'(id);
        if ((id > 31 || cpv < 2) && (set || clr)) am[bk(id)][id] = set;
        put('0, set, clr);
    endtask
    task automatic cand();
        logic [63:0] q;
        logic [9:0]  bi;
        logic [7:0]  bp;
        q = rnd() % 4 == 0 ? '0 : {rnd(), rnd()};
        bi = '0;
        bp = 8'hFF;
        for (int i = 63; i >= 0; i--) if (q[i] && pm[bk(i)][i] <= bp) {bi, bp} = {10'(i), pm[bk(i)][i]};
        cand_req <= q;
        cand_cpu <= cpv;
        put('0, 1'b0, 1'b0);
        @(negedge sys_clk);
        chk(best_valid === (q != 0) && best_id === bi && best_prio === bp, "best candidate");
        @(posedge sys_clk);
    endtask
    task automatic complete_run();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(negedge sys_clk) begin
        if (rq.size() > 0) chk(rdata === rq.pop_front(), "read data");
        else chk(rdata === '0, "read data outside answer cycle");
    end
    initial forever #25 sys_clk = ~sys_clk;
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        complete_run();
    end
    initial begin
        logic [31:0] x;
        int id;
        foreach (pm[c, i]) {pm[c][i], am[c][i]} = 9'h000;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        for (int i = 192; i < 195; i++) rd(i);
        for (int i = 256; i < 273; i++) rd(i);
        for (int i = 0; i < 400; i++) begin
            x = rnd();
            cpv = x[1:0] == 2'b11 ? 3'h2 : {2'b00, x[0]};
            nsv = x[2];
            lk = x[3];
            cfg_lock <= lk;
            if (i == 150) sec = {rnd(), rnd()};
            irq_secure <= sec;
            id = int'(x[21:16]);
            case (x[6:4])
                3'h0, 3'h1: begin
                    wr(256 + id / 4, rnd(), x[7] ? 4'hF : 4'(1 << (id % 4)));
                    rd(256 + id / 4);
                end
                3'h2: begin
                    ev(1'b1, x[8], id);
                    rd(192 + id / 32);
                end
                3'h3: begin
                    ev(1'b0, 1'b1, id);
                    rd(192 + id / 32);
                end
                3'h4: begin
                    rd(192 + id / 32);
                    wr(192 + id / 32, '1, 4'hF);
                    rd(192 + id / 32);
                end
                3'h5: begin
                    cpv = {2'b00, x[0]};
                    cand();
                end
                default: rd(int'(rnd() % 1024));
            endcase
        end
        put('0, 1'b0, 1'b0);
        repeat (2) @(posedge sys_clk);
        complete_run();
    end
endmodule
`default_nettype wire
